// ---- verilog/nfc_regs.svh ----
// Timing and field constants for the NOR flash host controller.
// Assumes a 50 MHz system clock; included by the package and modules.
//
// Contract
// - Host issues commands as ordinary bus writes to the command register.
// - Program is a four-write sequence; device times and verifies itself.
// - Elevated voltage on reset pin temporarily unprotects sectors.
// - Host may put device in standby to cut power.
// - Reads like async SRAM; data driven only with select and output enable.
`ifndef NFC_REGS_SVH
`define NFC_REGS_SVH
`define NFC_CLK_MHZ        50
`define NFC_T_SETUP_NS     30
`define NFC_T_PULSE_NS     40
`define NFC_T_HOLD_NS      20
`define NFC_T_ACCESS_NS    70
`define NFC_CYC(ns) (((ns) * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_ADDR_W         19
`define NFC_DATA_W         16
`define NFC_BIT_POLL       7
`define NFC_BIT_TOGGLE     6
`define NFC_BIT_TOP        15
`define NFC_UNLOCK_A1      19'h00555
`define NFC_UNLOCK_A2      19'h002AA
`define NFC_UNLOCK_D1      16'h00AA
`define NFC_UNLOCK_D2      16'h0055
`define NFC_CMD_PROG       16'h00A0
`define NFC_CMD_ERASE      16'h0080
`define NFC_CMD_CHIP       16'h0010
`define NFC_CMD_SECT       16'h0030
`define NFC_CMD_SUSP       16'h00B0
`define NFC_CMD_RESUME     16'h0030
`define NFC_CMD_RESET      16'h00F0
`endif

// ---- verilog/nfc_pkg.sv ----
// Types shared by the NOR flash host controller files.
// Assumes nfc_regs.svh sits on the include path.
`include "nfc_regs.svh"
package nfc_pkg;
  // Host operations taken at the user port
  typedef enum logic [2:0] {
    NFC_OP_READ   = 3'b000,
    NFC_OP_PROG   = 3'b001,
    NFC_OP_SECT   = 3'b010,
    NFC_OP_CHIP   = 3'b011,
    NFC_OP_SUSP   = 3'b100,
    NFC_OP_RESUME = 3'b101,
    NFC_OP_RESET  = 3'b110,
    NFC_OP_STATUS = 3'b111
  } nfc_op_t;
  // One user request
  typedef struct packed {
    nfc_op_t                 op;
    logic [`NFC_ADDR_W-1:0]  addr;
    logic [`NFC_DATA_W-1:0]  data;
  } nfc_req_t;
  // One bus cycle handed to the cycle engine
  typedef struct packed {
    logic                    wr;
    logic [`NFC_ADDR_W-1:0]  addr;
    logic [`NFC_DATA_W-1:0]  data;
  } nfc_cyc_t;
endpackage : nfc_pkg

// ---- verilog/nfc_bus_cycle.sv ----
// Single asynchronous bus cycle engine: one read or write per start.
// Assumes pin inputs are synchronous to i_clk_sys.
`timescale 1ns/1ns
`include "nfc_regs.svh"
module nfc_bus_cycle
  import nfc_pkg::*;
#(
  parameter int SETUP  = `NFC_CYC(`NFC_T_SETUP_NS),
  parameter int PULSE  = `NFC_CYC(`NFC_T_PULSE_NS),
  parameter int HOLD   = `NFC_CYC(`NFC_T_HOLD_NS),
  parameter int ACCESS = `NFC_CYC(`NFC_T_ACCESS_NS)
) (
  // Clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst,
  // Cycle request
  input  wire logic                   i_start,
  input  wire nfc_cyc_t               i_cyc,
  output logic                        o_done,
  output logic [`NFC_DATA_W-1:0]      o_rdata,
  // Flash pins
  output logic                        o_ce_n,
  output logic                        o_we_n,
  output logic                        o_oe_n,
  output logic [`NFC_ADDR_W-1:0]      o_addr,
  output logic [`NFC_DATA_W-1:0]      o_dq_out,
  output logic                        o_dq_oe,
  input  wire logic [`NFC_DATA_W-1:0] i_dq_in
);
  typedef enum logic [1:0] {
    NFC_C_IDLE  = 2'b00,
    NFC_C_SETUP = 2'b01,
    NFC_C_PULSE = 2'b10,
    NFC_C_HOLD  = 2'b11
  } nfc_cst_t;
  nfc_cst_t    state;
  nfc_cst_t    next_state;
  logic [7:0]  cnt;
  logic        wr;
  wire  [7:0]  pulse_len = wr ? 8'(PULSE) : 8'(ACCESS);
  wire         cnt_end;
  // Phase ends when the counter reaches one less than the phase length
  assign cnt_end = (state == NFC_C_SETUP) ? (cnt == 8'(SETUP - 1)) :
                   (state == NFC_C_PULSE) ? (cnt == pulse_len - 8'h01) :
                   (cnt == 8'(HOLD - 1));
  always_comb begin
    next_state = state;
    case (state)
      NFC_C_IDLE:  if (i_start) next_state = NFC_C_SETUP;
      NFC_C_SETUP: if (cnt_end) next_state = NFC_C_PULSE;
      NFC_C_PULSE: if (cnt_end) next_state = NFC_C_HOLD;
      NFC_C_HOLD:  if (cnt_end) next_state = NFC_C_IDLE;
      default:     next_state = NFC_C_IDLE;
    endcase
  end
  // Sequencer and pins; strobes are registered so no glitches reach the part
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state    <= NFC_C_IDLE;
      cnt      <= 8'h00;
      wr       <= 1'b0;
      o_done   <= 1'b0;
      o_rdata  <= '0;
      o_ce_n   <= 1'b1;
      o_we_n   <= 1'b1;
      o_oe_n   <= 1'b1;
      o_addr   <= '0;
      o_dq_out <= '0;
      o_dq_oe  <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= (next_state != state) ? 8'h00 : cnt + 8'h01;
      o_done <= (state == NFC_C_HOLD) && cnt_end;
      if (state == NFC_C_IDLE && i_start) begin
        wr       <= i_cyc.wr;
        o_addr   <= i_cyc.addr;
        o_dq_out <= i_cyc.data;
        o_dq_oe  <= i_cyc.wr;
        o_ce_n   <= 1'b0;
      end
      if (state == NFC_C_SETUP && cnt_end) begin
        o_we_n <= ~wr;
        o_oe_n <= wr;
      end
      if (state == NFC_C_PULSE && cnt_end) begin
        o_we_n <= 1'b1;
        o_oe_n <= 1'b1;
        if (!wr) o_rdata <= i_dq_in;
      end
      if (state == NFC_C_HOLD && cnt_end) begin
        o_ce_n  <= 1'b1;
        o_dq_oe <= 1'b0;
      end
    end
  end
endmodule : nfc_bus_cycle

// ---- verilog/nfc_host.sv ----
// NOR flash host controller: turns user operations into command write
// sequences, reads, and completion polling. Assumes a byte/word flash with
// separate select, write and output strobes and a ready/busy pin.
`timescale 1ns/1ns
`include "nfc_regs.svh"
module nfc_host
  import nfc_pkg::*;
#(
  parameter int  MAX_SECT  = 19,
  parameter int  POLL_MAX  = 65535
) (
  // Clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst,
  // User request
  input  wire logic                   i_req_valid,
  input  wire nfc_req_t               i_req,
  input  wire logic [MAX_SECT-1:0]    i_sect_mask,
  input  wire logic                   i_byte_mode,
  input  wire logic                   i_unprotect,
  input  wire logic                   i_standby,
  output logic                        o_req_ready,
  output logic                        o_done,
  output logic                        o_error,
  output logic [`NFC_DATA_W-1:0]      o_rdata,
  output logic                        o_flash_busy,
  // Flash pins
  output logic                        o_ce_n,
  output logic                        o_we_n,
  output logic                        o_oe_n,
  output logic                        o_byte_n,
  output logic                        o_reset_hv,
  output logic [`NFC_ADDR_W-1:0]      o_addr,
  output logic [`NFC_DATA_W-1:0]      o_dq_out,
  output logic                        o_dq_oe,
  input  wire logic [`NFC_DATA_W-1:0] i_dq_in,
  input  wire logic                   i_ready_busy_out,
  input  wire logic                   i_low_vcc
);
  typedef enum logic [2:0] {
    NFC_S_IDLE  = 3'b000,
    NFC_S_ISSUE = 3'b001,
    NFC_S_WAIT  = 3'b010,
    NFC_S_POLL  = 3'b011,
    NFC_S_PCHK  = 3'b100,
    NFC_S_END   = 3'b101
  } nfc_st_t;
  nfc_st_t                 state;
  nfc_st_t                 next_state;
  nfc_req_t                req;
  logic [MAX_SECT-1:0]     mask;
  logic [4:0]              step;
  logic [4:0]              last_step;
  logic [`NFC_DATA_W-1:0]  prev;
  logic                    have_prev;
  logic [15:0]             polls;
  logic                    err;
  logic                    cyc_start;
  logic                    cyc_done;
  logic [`NFC_DATA_W-1:0]  cyc_rdata;
  nfc_cyc_t                cyc;
  wire                     needs_poll;
  wire                     toggled;
  wire                     poll_ok;
  // Sector base address from index; bottom-boot layout, word addressing
  function automatic logic [`NFC_ADDR_W-1:0] sect_base(input logic [4:0] i);
    case (i)
      5'h00:   sect_base = 19'h00000;
      5'h01:   sect_base = 19'h02000;
      5'h02:   sect_base = 19'h03000;
      5'h03:   sect_base = 19'h04000;
      default: sect_base = {4'(i - 5'h03), 15'h0000};
    endcase
  endfunction : sect_base
  // Index of the sector selected by step during an erase
  wire [4:0] sidx = step - 5'h05;
  // Program: 4 writes; erase: 5 writes plus one per selected sector, or one chip command
  assign needs_poll = (req.op == NFC_OP_PROG) || (req.op == NFC_OP_SECT) ||
                      (req.op == NFC_OP_CHIP) || (req.op == NFC_OP_RESUME);
  // Bit 6 toggling between two reads means still busy
  assign toggled = have_prev &&
                   (cyc_rdata[`NFC_BIT_TOGGLE] != prev[`NFC_BIT_TOGGLE]);
  assign poll_ok = have_prev && !toggled &&
                   ((req.op != NFC_OP_PROG) ||
                    (cyc_rdata[`NFC_BIT_POLL] == req.data[`NFC_BIT_POLL]));
  // Build the current bus cycle from the operation and step
  always_comb begin
    cyc = '{wr: 1'b1, addr: `NFC_UNLOCK_A1, data: `NFC_UNLOCK_D1};
    last_step = 5'h00;
    case (req.op)
      NFC_OP_READ, NFC_OP_STATUS: begin
        cyc = '{wr: 1'b0, addr: req.addr, data: '0};
      end
      NFC_OP_PROG: begin
        last_step = 5'h03;
        case (step)
          5'h01:   cyc = '{1'b1, `NFC_UNLOCK_A2, `NFC_UNLOCK_D2};
          5'h02:   cyc = '{1'b1, `NFC_UNLOCK_A1, `NFC_CMD_PROG};
          5'h03:   cyc = '{1'b1, req.addr, req.data};
          default: cyc = '{1'b1, `NFC_UNLOCK_A1, `NFC_UNLOCK_D1};
        endcase
      end
      NFC_OP_SECT, NFC_OP_CHIP: begin
        last_step = (req.op == NFC_OP_CHIP) ? 5'h05 :
                    5'h05 + 5'(MAX_SECT - 1);
        case (step)
          5'h01, 5'h04: cyc = '{1'b1, `NFC_UNLOCK_A2, `NFC_UNLOCK_D2};
          5'h02: cyc = '{1'b1, `NFC_UNLOCK_A1, `NFC_CMD_ERASE};
          5'h00, 5'h03: cyc = '{1'b1, `NFC_UNLOCK_A1, `NFC_UNLOCK_D1};
          default:
            cyc = (req.op == NFC_OP_CHIP) ?
                  nfc_cyc_t'{1'b1, `NFC_UNLOCK_A1, `NFC_CMD_CHIP} :
                  nfc_cyc_t'{1'b1, sect_base(sidx), `NFC_CMD_SECT};
        endcase
      end
      NFC_OP_SUSP:   cyc = '{1'b1, req.addr, `NFC_CMD_SUSP};
      NFC_OP_RESUME: cyc = '{1'b1, req.addr, `NFC_CMD_RESUME};
      NFC_OP_RESET:  cyc = '{1'b1, req.addr, `NFC_CMD_RESET};
      default:       cyc = '{1'b0, req.addr, '0};
    endcase
  end
  // Sector writes are skipped for unselected sectors
  wire skip = (req.op == NFC_OP_SECT) && (step >= 5'h05) &&
              !mask[sidx];
  wire is_write = cyc.wr;
  // Writes are withheld while the supply is low
  wire blocked = is_write && i_low_vcc;
  always_comb begin
    next_state = state;
    case (state)
      NFC_S_IDLE:
        if (i_req_valid && !i_standby) next_state = NFC_S_ISSUE;
      NFC_S_ISSUE:
        if (blocked) next_state = NFC_S_END;
        else if (!skip) next_state = NFC_S_WAIT;
        else if (step == last_step) next_state = NFC_S_POLL;
      NFC_S_WAIT:
        if (cyc_done) begin
          if (step != last_step) next_state = NFC_S_ISSUE;
          else if (needs_poll) next_state = NFC_S_POLL;
          else next_state = NFC_S_END;
        end
      NFC_S_POLL: next_state = NFC_S_PCHK;
      NFC_S_PCHK:
        if (cyc_done) begin
          if (poll_ok || polls == 16'(POLL_MAX)) next_state = NFC_S_END;
          else next_state = NFC_S_POLL;
        end
      NFC_S_END:  next_state = NFC_S_IDLE;
      default:    next_state = NFC_S_IDLE;
    endcase
  end
  // Request capture, step counting, and polling state
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state     <= NFC_S_IDLE;
      req       <= '0;
      mask      <= '0;
      step      <= 5'h00;
      prev      <= '0;
      have_prev <= 1'b0;
      polls     <= 16'h0000;
      err       <= 1'b0;
      o_done    <= 1'b0;
      o_error   <= 1'b0;
      o_rdata   <= '0;
    end else begin
      state  <= next_state;
      o_done <= (state == NFC_S_END);
      if (state == NFC_S_IDLE && next_state == NFC_S_ISSUE) begin
        req       <= i_req;
        mask      <= i_sect_mask;
        step      <= 5'h00;
        have_prev <= 1'b0;
        polls     <= 16'h0000;
        err       <= 1'b0;
      end
      if (state == NFC_S_ISSUE && blocked) err <= 1'b1;
      if (state == NFC_S_ISSUE && skip && step != last_step)
        step <= step + 5'h01;
      if (state == NFC_S_WAIT && cyc_done) begin
        o_rdata <= cyc_rdata;
        if (step != last_step) step <= step + 5'h01;
      end
      if (state == NFC_S_PCHK && cyc_done) begin
        prev      <= cyc_rdata;
        have_prev <= 1'b1;
        polls     <= polls + 16'h0001;
        o_rdata   <= cyc_rdata;
        if (!poll_ok && polls == 16'(POLL_MAX)) err <= 1'b1;
      end
      if (state == NFC_S_END) o_error <= err;
    end
  end
  // Poll reads target the operation address with a plain read cycle
  assign cyc_start = (state == NFC_S_ISSUE && !blocked && !skip) ||
                     (state == NFC_S_POLL);
  wire nfc_cyc_t cyc_sel = (state == NFC_S_POLL) ?
                           nfc_cyc_t'{1'b0, req.addr, '0} : cyc;
  assign o_req_ready  = (state == NFC_S_IDLE) && !i_standby;
  assign o_flash_busy = !i_ready_busy_out;
  assign o_byte_n     = !i_byte_mode;
  assign o_reset_hv   = i_unprotect;
  nfc_bus_cycle u_cycle (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_start   (cyc_start),
    .i_cyc     (cyc_sel),
    .o_done    (cyc_done),
    .o_rdata   (cyc_rdata),
    .o_ce_n    (o_ce_n),
    .o_we_n    (o_we_n),
    .o_oe_n    (o_oe_n),
    .o_addr    (o_addr),
    .o_dq_out  (o_dq_out),
    .o_dq_oe   (o_dq_oe),
    .i_dq_in   (i_dq_in)
  );
endmodule : nfc_host

// ---- verification/nfc_host_properties.sv ----
// Checker for the flash controller pins and user handshake.
// Assumes it is bound to nfc_host and sees only its ports.
`timescale 1ns/1ns
`include "nfc_regs.svh"
module nfc_host_properties
  import nfc_pkg::*;
(
  // Clock, reset and user side
  input  wire logic     i_clk_sys,
  input  wire logic     i_rst,
  input  wire logic     i_req_valid,
  input  wire nfc_req_t i_req,
  input  wire logic     i_byte_mode,
  input  wire logic     i_unprotect,
  input  wire logic     i_standby,
  input  wire logic     i_ready_busy_out,
  input  wire logic     o_req_ready,
  input  wire logic     o_done,
  input  wire logic     o_error,
  input  wire logic     o_flash_busy,
  // Flash strobes
  input  wire logic     o_ce_n,
  input  wire logic     o_we_n,
  input  wire logic     o_oe_n,
  input  wire logic     o_byte_n,
  input  wire logic     o_reset_hv,
  input  wire logic     o_dq_oe
);
  default clocking dcb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // Request accepted at this edge
  wire taken = i_req_valid && o_req_ready;
  AST_BYTE_PIN: assert property (o_byte_n == !i_byte_mode)
    else $error("byte select pin does not follow the mode");
  AST_UNPROT: assert property (o_reset_hv == i_unprotect)
    else $error("reset high voltage does not follow request");
  AST_BUSY: assert property (o_flash_busy == !i_ready_busy_out)
    else $error("busy flag does not mirror ready pin");
  AST_READ_BUS: assert property (!o_oe_n |-> !o_ce_n && !o_dq_oe && o_we_n)
    else $error("read strobe without select or with data driven");
  AST_WRITE_BUS: assert property (!o_we_n |-> !o_ce_n && o_dq_oe)
    else $error("write strobe without select or data");
  AST_WE_WIDTH: assert property ($fell(o_we_n) |=> !o_we_n ##1 o_we_n)
    else $error("write strobe width wrong");
  AST_ONE_OP: assert property (taken |=> !o_req_ready ##1 !o_req_ready)
    else $error("second request taken while busy");
  AST_READ_LAT: assert property (
      taken && i_req.op == NFC_OP_READ |-> ##[8:14] o_done)
    else $error("read did not finish in time");
  AST_STANDBY: assert property (i_standby |-> !o_req_ready
      && (!$past(o_ce_n) || o_ce_n))
    else $error("request or select during standby");
  // Main scenarios reached
  cover property (taken && i_req.op == NFC_OP_PROG);
  cover property (taken && i_req.op == NFC_OP_SECT);
  cover property (o_done && o_error);
endmodule : nfc_host_properties
bind nfc_host nfc_host_properties u_props (.i_clk_sys(i_clk_sys),
  .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req(i_req),
  .i_byte_mode(i_byte_mode), .i_unprotect(i_unprotect),
  .i_standby(i_standby), .i_ready_busy_out(i_ready_busy_out),
  .o_req_ready(o_req_ready), .o_done(o_done), .o_error(o_error),
  .o_flash_busy(o_flash_busy), .o_ce_n(o_ce_n), .o_we_n(o_we_n),
  .o_oe_n(o_oe_n), .o_byte_n(o_byte_n), .o_reset_hv(o_reset_hv),
  .o_dq_oe(o_dq_oe));

// ---- verification/nfc_flash_model.sv ----
// Behavioural model of the parallel flash, word organised, bottom boot.
// Assumes host pin changes are synchronous to the system clock.
`timescale 1ns/1ns
`include "nfc_regs.svh"
module nfc_flash_model #(
  parameter int          T_PROG  = 30,
  parameter int          T_ERASE = 80,
  parameter logic [18:0] PROT    = 19'h00004
) (
  // Clock and host pins
  input  wire logic        i_clk_sys,
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_reset_hv,
  input  wire logic [18:0] i_addr,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_low_vcc,
  // Device outputs
  output logic [15:0]      o_dq = 16'h0000,
  output logic             o_ready_busy_out
);
  logic [15:0] mem [int];
  logic [18:0] emask = '0;
  logic [18:0] pa;
  logic [15:0] pd = '0;
  logic [2:0]  step = '0;
  logic        we_q = 1'b1, oe_q = 1'b1, tog = 1'b0, ers = 1'b0;
  int          cnt = 0;
  // Sector index; slow to change, so kept as a plain function
  function automatic int sect_of(input logic [18:0] a);
    if (a < 19'h02000) return 0;
    if (a < 19'h04000) return (a < 19'h03000) ? 1 : 2;
    return (a < 19'h08000) ? 3 : 3 + int'(a[18:15]);
  endfunction : sect_of
  function automatic logic open(input logic [18:0] a);
    return !PROT[sect_of(a)] || i_reset_hv;
  endfunction : open
  function automatic logic [15:0] rd(input logic [18:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
  endfunction : rd
  // Status word and ready pin while the embedded timer runs
  wire [15:0] stat = {8'h00, ers ? 1'b0 : ~pd[7], tog, 6'h00};
  assign o_ready_busy_out = (cnt == 0);
  // Command decode, embedded timer and read port
  always @(posedge i_clk_sys) begin
    int q[$];
    if (!we_q && i_we_n && !i_ce_n && !i_low_vcc) begin
      if (step == 3'd3 && open(i_addr)) begin
        pa <= i_addr;
        pd <= i_dq;
        cnt <= T_PROG;
        ers <= 1'b0;
      end
      if (step == 3'd6 && i_dq == `NFC_CMD_SECT) begin
        emask[sect_of(i_addr)] <= 1'b1;
        cnt <= T_ERASE;
        ers <= 1'b1;
      end else if (step == 3'd6 && i_dq == `NFC_CMD_CHIP) begin
        emask <= '1;
        cnt <= T_ERASE;
        ers <= 1'b1;
        step <= 3'd0;
      end else if (step != 3'd3 && i_dq == `NFC_UNLOCK_D1)
        step <= (step == 3'd4) ? 3'd5 : 3'd1;
      else if (step != 3'd3 && i_dq == `NFC_UNLOCK_D2)
        step <= (step == 3'd5) ? 3'd6 : 3'd2;
      else if (step == 3'd2 && i_dq == `NFC_CMD_PROG)
        step <= 3'd3;
      else if (step == 3'd2 && i_dq == `NFC_CMD_ERASE) begin
        step <= 3'd4;
        emask <= '0;
      end else
        step <= 3'd0;
    end
    if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1 && !ers) mem[int'(pa)] = rd(pa) & pd;
      if (cnt == 1 && ers) begin
        q.delete(); // Keys from an earlier erase must not be hit again
        foreach (mem[k]) if (emask[sect_of(19'(k))] && open(19'(k)))
          q.push_back(k);
        foreach (q[j]) mem.delete(q[j]);
      end
    end
    if (!i_ce_n && !i_oe_n) begin
      o_dq <= (cnt > 0) ? stat : rd(i_addr);
      if (oe_q) tog <= ~tog;
    end else
      o_dq <= ~o_dq; // Released bus wanders instead of keeping data
    we_q <= i_we_n;
    oe_q <= i_oe_n;
  end
endmodule : nfc_flash_model

// ---- verification/nfc_host_tb_top.sv ----
// Self-checking bench: controller against the behavioural flash model.
// Assumes the package, design and model files are compiled first.
`timescale 1ns/1ns
`include "nfc_regs.svh"
module nfc_host_tb_top
  import nfc_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, valid = 1'b0, bytem = 1'b0;
  logic        unprot = 1'b0, stby = 1'b0, lowv = 1'b0;
  logic [18:0] smask = '0;
  nfc_req_t    req = '0;
  logic [17:0] expq[$];
  logic [17:0] e;
  logic [31:0] seed = 32'h38B8;
  logic [18:0] a[3];
  logic [15:0] d[3];
  int          comparisons = 0, miscompares = 0, cycles = 0, i;
  wire         rdy, done, err, fbusy, ce_n, we_n, oe_n, byte_n, hv, dq_oe, rb;
  wire [15:0]  rdata, dq_out, f_dq;
  wire [18:0]  addr;
  wire [15:0]  dq = dq_oe ? dq_out : f_dq; // Shared data line
  nfc_host #(.MAX_SECT(19), .POLL_MAX(40)) uut (.i_clk_sys(clk),
    .i_rst(rst), .i_req_valid(valid), .i_req(req), .i_sect_mask(smask),
    .i_byte_mode(bytem), .i_unprotect(unprot), .i_standby(stby),
    .o_req_ready(rdy), .o_done(done), .o_error(err), .o_rdata(rdata),
    .o_flash_busy(fbusy), .o_ce_n(ce_n), .o_we_n(we_n), .o_oe_n(oe_n),
    .o_byte_n(byte_n), .o_reset_hv(hv), .o_addr(addr),
    .o_dq_out(dq_out), .o_dq_oe(dq_oe), .i_dq_in(dq),
    .i_ready_busy_out(rb), .i_low_vcc(lowv));
  nfc_flash_model u_flash (.i_clk_sys(clk), .i_ce_n(ce_n), .i_we_n(we_n),
    .i_oe_n(oe_n), .i_reset_hv(hv), .i_addr(addr), .i_dq(dq),
    .i_low_vcc(lowv), .o_dq(f_dq), .o_ready_busy_out(rb));
  always #10 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [15:0] ex,
                     input logic [15:0] got);
    comparisons++;
    if (got !== ex) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic summarize;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // Note {check data, error, data}, hand over, wait for completion
  task automatic op(input nfc_op_t o, input logic [18:0] ad,
                    input logic [15:0] dt, input logic [17:0] ex);
    int k;
    expq.push_back(ex);
    valid <= 1'b1;
    req <= '{o, ad, dt};
    @(posedge clk);
    for (k = 0; k < 50 && rdy !== 1'b1; k++) @(posedge clk);
    valid <= 1'b0;
    for (k = 0; k < 3000 && done !== 1'b1; k++) @(posedge clk);
    if (k == 3000) begin
      miscompares++;
      $display("[ERR] done expected 1 seen 0");
      void'(expq.pop_back());
    end
    @(posedge clk);
  endtask : op
  // Hang guard: generous against little more than a thousand cycles of traffic
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      summarize();
    end
  end
  // Each completion is paired with the oldest note
  always @(negedge clk) begin
    if (!rst && done === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : 18'h3FFFF;
      chk("error", {15'h0, e[16]}, {15'h0, err});
      if (e[17]) chk("rdata", e[15:0], rdata);
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    op(NFC_OP_READ, 19'h00100, 16'h0, {2'b10, 16'hFFFF});
    op(NFC_OP_STATUS, 19'h7FFFF, 16'h0, {2'b10, 16'hFFFF});
    for (i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      a[i] = {4'(i + 1), seed[14:0]};
      d[i] = seed[31:16];
      op(NFC_OP_PROG, a[i], d[i], 18'h0);
      op(NFC_OP_READ, a[i], 16'h0, {2'b10, d[i]});
      seed = lfsr(seed);
      op(NFC_OP_PROG, a[i], seed[15:0] & 16'hFF7F, 18'h0);
      d[i] = d[i] & seed[15:0] & 16'hFF7F;
      op(NFC_OP_READ, a[i], 16'h0, {2'b10, d[i]});
    end
    smask <= 19'h00010;
    op(NFC_OP_SECT, a[0], 16'h0, 18'h0);
    op(NFC_OP_READ, a[0], 16'h0, {2'b10, 16'hFFFF});
    op(NFC_OP_READ, a[1], 16'h0, {2'b10, d[1]});
    op(NFC_OP_PROG, 19'h03010, 16'h00F0, 18'h0);
    op(NFC_OP_READ, 19'h03010, 16'h0, {2'b10, 16'hFFFF});
    unprot <= 1'b1;
    op(NFC_OP_PROG, 19'h03010, 16'h00F0, 18'h0);
    unprot <= 1'b0;
    lowv <= 1'b1;
    op(NFC_OP_PROG, 19'h09000, 16'h0000, {2'b01, 16'h0});
    lowv <= 1'b0;
    op(NFC_OP_READ, 19'h09000, 16'h0, {2'b10, 16'hFFFF});
    stby <= 1'b1;
    bytem <= 1'b1;
    repeat (3) @(negedge clk);
    chk("ready", 16'h0, {15'h0, rdy});
    chk("byte_n", 16'h0, {15'h0, byte_n});
    @(posedge clk);
    stby <= 1'b0;
    bytem <= 1'b0;
    op(NFC_OP_CHIP, 19'h0, 16'h0, 18'h0);
    op(NFC_OP_READ, a[2], 16'h0, {2'b10, 16'hFFFF});
    op(NFC_OP_READ, 19'h03010, 16'h0, {2'b10, 16'h00F0});
    op(NFC_OP_SUSP, a[1], 16'h0, 18'h0);
    op(NFC_OP_RESUME, a[1], 16'h0, 18'h0);
    op(NFC_OP_RESET, 19'h0, 16'h0, 18'h0);
    op(NFC_OP_READ, a[1], 16'h0, {2'b10, 16'hFFFF});
    summarize();
  end
endmodule : nfc_host_tb_top
